// file: core/nv_fuse_cell.sv
// One nonvolatile fuse or lock byte stored as erased or cleared
`timescale 1ns/1ps
module nv_fuse_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Erase and program strobes
  input wire logic erase,
  input wire logic prog,
  input wire logic [7:0] prog_data,
  // Stored byte
  output logic [7:0] value
);
  import nvm_pkg::*;

  // One bit of state is enough, the byte is only ever FFh or 00h
  logic erased_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      erased_reg <= 1'b1;
    end else if (erase) begin
      // Erase first, then program within the same operation
      erased_reg <= !(prog && prog_data == BYTE_CLEARED);
    end else if (prog && prog_data == BYTE_CLEARED) begin
      erased_reg <= 1'b0;
    end
  end

  assign value = erased_reg ? BYTE_ERASED : BYTE_CLEARED;
endmodule : nv_fuse_cell

// file: core/nv_poll_tracker.sv
// Busy timer and data polling read path
`timescale 1ns/1ps
module nv_poll_tracker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle starts with polling reference
  input wire logic start_write,
  input wire logic start_erase,
  input wire logic [6:0] ref_idx,
  input wire logic [7:0] ref_val,
  // Read path
  input wire logic [6:0] rd_idx,
  input wire logic [7:0] rd_mem,
  output logic [7:0] rd_val,
  // Cycle state
  output logic busy,
  output logic done,
  output logic [6:0] poll_idx,
  output logic [7:0] poll_val
);
  import nvm_pkg::*;

  logic [15:0] count_reg; // Cycles left in the current cycle
  logic [6:0] idx_reg; // Location being polled
  logic [7:0] val_reg; // Value that location will hold

  // Remaining cycle count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
    end else if (start_erase) begin
      count_reg <= ERASE_CYCLES;
    end else if (start_write) begin
      count_reg <= PROG_CYCLES;
    end else if (count_reg != 16'h0000) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // Polling reference captured at cycle start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg <= 7'h00;
      val_reg <= BYTE_ERASED;
    end else if (start_erase) begin
      idx_reg <= ref_idx;
      val_reg <= BYTE_ERASED;
    end else if (start_write) begin
      // last loaded byte is the reference
      idx_reg <= ref_idx;
      val_reg <= ref_val;
    end
  end

  assign busy = count_reg != 16'h0000;
  assign done = count_reg == 16'h0001;
  assign poll_idx = idx_reg;
  assign poll_val = val_reg;

  // complemented MSB at the polled location while busy, true value otherwise
  assign rd_val = (busy && rd_idx == idx_reg) ? (val_reg ^ MSB_MASK) : rd_mem;
endmodule : nv_poll_tracker

// file: core/nvm_access_top.sv
// Lock bits, fuse row, data polling and Avalon-MM register slave
`timescale 1ns/1ps
module nvm_access_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Decoded configuration
  output nvm_pkg::nv_cfg_t cfg
);
  import nvm_pkg::*;

  logic wait_reg; // Waitrequest flop
  logic [31:0] rdata_reg; // Read data flop
  nv_cfg_t cfg_reg; // Configuration outputs
  logic [6:0] addr_reg; // Space and byte address
  logic [4:0] last_idx_reg; // Last loaded page byte
  logic [7:0] last_val_reg; // Last loaded data value
  logic [PAGE_BYTES-1:0] mask_reg; // Page bytes loaded
  logic [PAGE_BYTES-1:0] op_mask_reg; // Page bytes owned by the running write
  logic [7:0] fuse_at_addr; // Fuse byte under the address register
  logic [1:0] op_space_reg; // Space of the running write
  op_state_t op_reg; // Running operation
  logic reject_reg; // Last command refused
  logic [7:0] mem [0:MEM_BYTES-1]; // Code, data and signature storage
  logic [7:0] pbuf [0:PAGE_BYTES-1]; // Page buffer
  logic [7:0] fuse_val [0:FUSE_COUNT-1]; // Fuse row bytes
  logic [7:0] lock_val [0:LOCK_COUNT-1]; // Lock bytes

  // Bus strobes
  logic wr_take;
  logic rd_take;
  logic rd_done;
  logic cmd_hit;
  logic [3:0] cmd;
  logic [7:0] cmd_data;
  logic [1:0] space;
  prot_mode_t mode;
  logic ext_write_ok;
  logic page_ok;
  logic app_ok;
  logic start_write;
  logic start_erase;
  logic fuse_prog;
  logic lock_prog;
  logic session_end;
  logic accepted;
  logic poll_busy;
  logic poll_done;
  logic [6:0] poll_idx;
  logic [7:0] poll_val;
  logic [7:0] poll_rd;
  logic [7:0] rd_byte;
  logic erase_done;
  logic write_done;

  // Write acts at the edge where waitrequest is low; read data made one edge earlier
  assign wr_take = avs_write && !wait_reg && avs_byteenable[0];
  assign rd_take = avs_read && wait_reg;
  assign rd_done = avs_read && !wait_reg;
  assign cmd_hit = wr_take && avs_address == OFF_CMD;
  assign cmd = avs_writedata[3:0];
  assign cmd_data = avs_writedata[15:8];
  assign space = addr_reg[6:5];
  assign erase_done = poll_done && op_reg == OP_ERASE;
  assign write_done = poll_done && op_reg == OP_WRITE;

  // decode protection mode from the lock bytes
  always_comb begin
    if (lock_val[0] == BYTE_CLEARED && lock_val[1] == BYTE_CLEARED) begin
      mode = MODE_NO_ACCESS;
    end else if (lock_val[0] == BYTE_CLEARED || lock_val[1] == BYTE_CLEARED) begin
      // Odd pattern 0FFh/00h is treated as the weaker lock
      mode = MODE_NO_WRITE;
    end else begin
      mode = MODE_OPEN;
    end
  end

  assign ext_write_ok = mode == MODE_OPEN;
  // signature programming needs its fuse cleared
  assign page_ok = ext_write_ok && space != SPACE_FUSE
    && (space != SPACE_SIG || fuse_val[F_SIG_PROG] == BYTE_CLEARED);
  assign app_ok = space == SPACE_DATA
    || (space != SPACE_FUSE && fuse_val[F_IAP] == BYTE_CLEARED);

  // Command decode; nothing starts while a cycle runs
  assign start_write = cmd_hit && !poll_busy
    && ((cmd == CMD_WRITE_PAGE && page_ok) || (cmd == CMD_APP_WRITE && app_ok));
  assign start_erase = cmd_hit && !poll_busy && cmd == CMD_CHIP_ERASE;
  // one fuse per byte address; debug interface fuse never cleared
  assign fuse_prog = cmd_hit && !poll_busy && ext_write_ok && space == SPACE_FUSE
    && (cmd == CMD_WRITE_FUSE || cmd == CMD_WRITE_FUSE_AE) && !addr_reg[4]
    && addr_reg[3:0] < 4'(FUSE_COUNT)
    && !(addr_reg[3:0] == FUSE_DEBUG_IF_ADDR && cmd_data == BYTE_CLEARED);
  assign lock_prog = cmd_hit && !poll_busy && cmd == CMD_WRITE_LOCK
    && space == SPACE_FUSE && addr_reg[4] && addr_reg[3:1] == 3'h0;
  assign session_end = cmd_hit && cmd == CMD_SESSION_END;
  assign accepted = start_write || start_erase || fuse_prog || lock_prog || session_end;

  // Fuse row cells
  genvar gi;
  generate
    for (gi = 0; gi < FUSE_COUNT; gi++) begin : g_fuse
      // auto-erase write erases the row before programming
      nv_fuse_cell u_cell (
        .clk(clk),
        .rst(rst),
        .erase(fuse_prog && cmd == CMD_WRITE_FUSE_AE),
        .prog(fuse_prog && addr_reg[3:0] == 4'(gi)),
        .prog_data(cmd_data),
        .value(fuse_val[gi])
      );
    end
    for (gi = 0; gi < LOCK_COUNT; gi++) begin : g_lock
      // lock cells erase only at chip erase completion
      nv_fuse_cell u_cell (
        .clk(clk),
        .rst(rst),
        .erase(erase_done),
        .prog(lock_prog && addr_reg[0] == 1'(gi)),
        .prog_data(cmd_data),
        .value(lock_val[gi])
      );
    end
  endgenerate

  // Busy timer and polling path
  nv_poll_tracker u_poll (
    .clk(clk),
    .rst(rst),
    .start_write(start_write),
    .start_erase(start_erase),
    .ref_idx({space, last_idx_reg}),
    .ref_val(last_val_reg),
    .rd_idx(addr_reg),
    .rd_mem(mem[addr_reg]),
    .rd_val(poll_rd),
    .busy(poll_busy),
    .done(poll_done),
    .poll_idx(poll_idx),
    .poll_val(poll_val)
  );

  // Operation tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_reg <= OP_IDLE;
      op_space_reg <= SPACE_CODE;
    end else if (start_erase) begin
      op_reg <= OP_ERASE;
    end else if (start_write) begin
      op_reg <= OP_WRITE;
      op_space_reg <= space;
    end else if (poll_done) begin
      op_reg <= OP_IDLE;
    end
  end

  // Storage array; contents persist and are not touched by reset
  always_ff @(posedge clk) begin
    if (write_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (op_mask_reg[i]) begin
          mem[{op_space_reg, 5'(i)}] <= pbuf[i];
        end
      end
    end else if (erase_done) begin
      // Signature page erases only when its programming fuse is enabled
      for (int i = 0; i < SIG_END; i++) begin
        if (i < DATA_END || fuse_val[F_SIG_PROG] == BYTE_CLEARED) begin
          mem[i] <= BYTE_ERASED;
        end
      end
    end
  end

  // Page buffer data
  always_ff @(posedge clk) begin
    if (wr_take && avs_address == OFF_WDATA) begin
      pbuf[addr_reg[4:0]] <= avs_writedata[7:0];
    end
  end

  // Page load tracking; loads during a cycle go to the next page
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= '0;
      last_idx_reg <= 5'h00;
      last_val_reg <= BYTE_ERASED;
    end else if (wr_take && avs_address == OFF_WDATA) begin
      mask_reg[addr_reg[4:0]] <= 1'b1;
      last_idx_reg <= addr_reg[4:0];
      last_val_reg <= avs_writedata[7:0];
    end else if (start_write) begin
      mask_reg <= '0;
    end
  end

  // Bytes to commit, frozen at start; a byte reloaded mid-cycle replaces its buffer slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_mask_reg <= '0;
    end else if (start_write) begin
      op_mask_reg <= mask_reg;
    end
  end

  // Address register, byte part steps after each data byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 7'h00;
    end else if (wr_take && avs_address == OFF_ADDR) begin
      addr_reg <= {avs_writedata[9:8], avs_writedata[4:0]};
    end else if ((wr_take && avs_address == OFF_WDATA)
        || (rd_done && avs_address == OFF_RDATA)) begin
      addr_reg[4:0] <= addr_reg[4:0] + 5'h01;
    end
  end

  // Refusal flag reflects the most recent command only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reject_reg <= 1'b0;
    end else if (cmd_hit) begin
      reject_reg <= !accepted;
    end
  end

  // Byte returned through the data read register
  always_comb begin
    rd_byte = poll_rd;
    if (space == SPACE_FUSE) begin
      // Fuses and locks stay readable in every mode
      if (addr_reg[4]) begin
        rd_byte = lock_val[addr_reg[0]];
      end else if (addr_reg[3:0] < 4'(FUSE_COUNT)) begin
        rd_byte = fuse_val[addr_reg[3:0]];
      end else begin
        rd_byte = BYTE_ERASED;
      end
    end else if (mode == MODE_NO_ACCESS && space != SPACE_SIG) begin
      rd_byte = BYTE_CLEARED;
    end
  end

  // Waitrequest: one wait cycle, then one answer cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (avs_address)
        OFF_ADDR: rdata_reg <= {22'h0, addr_reg[6:5], 3'h0, addr_reg[4:0]};
        OFF_WDATA: rdata_reg <= {24'h0, last_val_reg};
        OFF_RDATA: rdata_reg <= {24'h0, rd_byte};
        OFF_STATUS: rdata_reg <= {27'h0, op_reg == OP_ERASE, reject_reg, mode, poll_busy};
        OFF_CFG: rdata_reg <= {3'h0, cfg_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Start-up time-out from source class and selection
  function automatic logic [14:0] sut_lookup(input logic crystal_osc, input logic [1:0] sel);
    logic [14:0] t;
    t = SUT_RC_3;
    unique case (sel)
      2'h0: t = crystal_osc ? SUT_CRYSTAL_OSC_0 : SUT_RC_0;
      2'h1: t = crystal_osc ? SUT_CRYSTAL_OSC_1 : SUT_RC_1;
      2'h2: t = crystal_osc ? SUT_CRYSTAL_OSC_2 : SUT_RC_2;
      2'h3: t = crystal_osc ? SUT_CRYSTAL_OSC_3 : SUT_RC_3;
    endcase
    return t;
  endfunction : sut_lookup

  // Decoded configuration outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else begin
      // clock source from the two select fuses
      cfg_reg.clk_src <= clk_src_t'({fuse_val[F_CLK_SRC_SEL_HI][0],
        fuse_val[F_CLK_SRC_SEL_LO][0]});
      cfg_reg.startup_delay_sel <= {fuse_val[F_STARTUP_DELAY_SEL_HI][0],
        fuse_val[F_STARTUP_DELAY_SEL_LO][0]};
      cfg_reg.startup_timeout_us <= sut_lookup(!fuse_val[F_CLK_SRC_SEL_HI][0],
        {fuse_val[F_STARTUP_DELAY_SEL_HI][0], fuse_val[F_STARTUP_DELAY_SEL_LO][0]});
      // brown-out, signature and application programming enables
      cfg_reg.brownout_detector_en <= fuse_val[F_BROWNOUT][0];
      cfg_reg.user_sig_prog_en <= !fuse_val[F_SIG_PROG][0];
      cfg_reg.iap_en <= !fuse_val[F_IAP][0];
      // debug off in the strongest lock mode
      cfg_reg.on_chip_debug_en <= !fuse_val[F_DEBUG][0] && mode != MODE_NO_ACCESS;
      cfg_reg.ports_input_only <= fuse_val[F_TRISTATE][0];
      cfg_reg.ocd_fast_if <= fuse_val[F_DEBUG_IF][0];
      cfg_reg.prot_mode <= mode;
      // pin and entry fuses change only at session end
      if (session_end) begin
        cfg_reg.reset_pin_en <= fuse_val[F_RESET_PIN][0];
        // programming entry any time or at power-on only
        cfg_reg.isp_anytime <= fuse_val[F_ISP][0];
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign cfg = cfg_reg;

  // Fuse under the address, out-of-row indices read as erased
  assign fuse_at_addr = (addr_reg[3:0] < 4'(FUSE_COUNT)) ? fuse_val[addr_reg[3:0]] : BYTE_ERASED;

  // Checks on the running design
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_poll_msb_flip: assert property (
    rd_take && avs_address == OFF_RDATA && op_reg == OP_WRITE && poll_busy
      && space != SPACE_FUSE && mode != MODE_NO_ACCESS && addr_reg == poll_idx
    |=> avs_readdata[7:0] == (poll_val ^ MSB_MASK))
    else $error("busy poll read did not invert the msb");
  a_poll_true_value: assert property (
    write_done && op_mask_reg[poll_idx[4:0]] |=> mem[$past(poll_idx)] == $past(poll_val))
    else $error("polled location does not hold its true value after the cycle");
  a_erase_poll_7f: assert property (
    rd_take && avs_address == OFF_RDATA && op_reg == OP_ERASE && poll_busy
      && space != SPACE_FUSE && mode != MODE_NO_ACCESS && addr_reg == poll_idx
    |=> avs_readdata[7:0] == 8'h7f)
    else $error("erase poll did not read 7fh");
  a_poll_ref_last: assert property (
    start_write |=> poll_val == $past(last_val_reg) && poll_idx[4:0] == $past(last_idx_reg))
    else $error("poll reference is not the last loaded byte");
  a_lock_erase_only: assert property (
    $changed(lock_val[0]) && lock_val[0] == BYTE_ERASED |-> $past(erase_done))
    else $error("lock byte returned to ffh without chip erase");
  a_mode_output: assert property (
    lock_val[0] == BYTE_CLEARED && lock_val[1] == BYTE_CLEARED |=> cfg.prot_mode == MODE_NO_ACCESS)
    else $error("both locks cleared but mode 3 not shown");
  a_locked_no_fuse: assert property (
    cmd_hit && mode != MODE_OPEN && (cmd == CMD_WRITE_FUSE || cmd == CMD_WRITE_FUSE_AE)
    |=> $stable(fuse_at_addr))
    else $error("fuse changed while locked");
  a_mode3_read_zero: assert property (
    rd_take && avs_address == OFF_RDATA && mode == MODE_NO_ACCESS && space == SPACE_CODE
    |=> avs_readdata == 32'h0000_0000)
    else $error("code read not blocked in mode 3");
  a_app_bypass: assert property (
    cmd_hit && !poll_busy && cmd == CMD_APP_WRITE && space == SPACE_DATA |=> op_reg == OP_WRITE ##0 poll_busy)
    else $error("application data write refused");
  a_pin_fuse_hold: assert property (
    !session_end |=> $stable(cfg.reset_pin_en) && $stable(cfg.isp_anytime))
    else $error("pin fuse effect changed outside session end");
  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  c_page_write: cover property (start_write ##[1:200] write_done);
  c_chip_erase: cover property (start_erase ##[1:300] erase_done);
  c_lock_mode3: cover property (mode == MODE_NO_ACCESS);
endmodule : nvm_access_top

// file: core/nvm_pkg.sv
// Constants and types for the nonvolatile lock, fuse and polling block
package nvm_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_ADDR = 5'h04;
  localparam logic [4:0] OFF_WDATA = 5'h08;
  localparam logic [4:0] OFF_RDATA = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_CFG = 5'h14;
  // Command codes in CMD[3:0]; CMD[15:8] carries fuse or lock data
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h1;
  localparam logic [3:0] CMD_WRITE_PAGE = 4'h2;
  localparam logic [3:0] CMD_WRITE_FUSE = 4'h3;
  localparam logic [3:0] CMD_WRITE_FUSE_AE = 4'h4;
  localparam logic [3:0] CMD_WRITE_LOCK = 4'h5;
  localparam logic [3:0] CMD_APP_WRITE = 4'h6;
  localparam logic [3:0] CMD_SESSION_END = 4'h7;
  // Memory spaces in ADDR[9:8]
  localparam logic [1:0] SPACE_CODE = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_SIG = 2'h2;
  localparam logic [1:0] SPACE_FUSE = 2'h3;
  // Byte values
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] BYTE_CLEARED = 8'h00;
  localparam logic [7:0] MSB_MASK = 8'h80;
  // Sizes
  localparam int FUSE_COUNT = 12;
  localparam int LOCK_COUNT = 2;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 128;
  localparam int SIG_END = 96;
  localparam int DATA_END = 64;
  // Fuse indices inside the fuse row
  localparam int F_CLK_SRC_SEL_HI = 0;
  localparam int F_CLK_SRC_SEL_LO = 1;
  localparam int F_STARTUP_DELAY_SEL_HI = 2;
  localparam int F_STARTUP_DELAY_SEL_LO = 3;
  localparam int F_RESET_PIN = 4;
  localparam int F_BROWNOUT = 5;
  localparam int F_DEBUG = 6;
  localparam int F_ISP = 7;
  localparam int F_SIG_PROG = 8;
  localparam int F_TRISTATE = 9;
  localparam int F_DEBUG_IF = 10;
  localparam int F_IAP = 11;
  localparam logic [3:0] FUSE_DEBUG_IF_ADDR = 4'ha;
  // Programming cycle timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS = 400;
  localparam int ERASE_TIME_NS = 800;
  localparam logic [15:0] PROG_CYCLES = 16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ERASE_CYCLES = 16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Start-up time-outs in microseconds
  localparam logic [14:0] SUT_CRYSTAL_OSC_0 = 15'h03e8;
  localparam logic [14:0] SUT_CRYSTAL_OSC_1 = 15'h07d0;
  localparam logic [14:0] SUT_CRYSTAL_OSC_2 = 15'h0fa0;
  localparam logic [14:0] SUT_CRYSTAL_OSC_3 = 15'h3e80;
  localparam logic [14:0] SUT_RC_0 = 15'h0010;
  localparam logic [14:0] SUT_RC_1 = 15'h0200;
  localparam logic [14:0] SUT_RC_2 = 15'h03e8;
  localparam logic [14:0] SUT_RC_3 = 15'h0fa0;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_REJECT = 3;
  localparam int ST_ERASE = 4;

  typedef enum logic [1:0] {MODE_OPEN, MODE_NO_WRITE, MODE_NO_ACCESS} prot_mode_t;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} op_state_t;
  typedef enum logic [1:0] {CLK_HS_CRYSTAL_OSC, CLK_LS_CRYSTAL_OSC, CLK_EXT, CLK_IRC} clk_src_t;

  // Decoded configuration seen by the rest of the chip
  typedef struct packed {
    clk_src_t clk_src;
    logic [1:0] startup_delay_sel;
    logic [14:0] startup_timeout_us;
    logic reset_pin_en;
    logic brownout_detector_en;
    logic on_chip_debug_en;
    logic isp_anytime;
    logic user_sig_prog_en;
    logic ports_input_only;
    logic ocd_fast_if;
    logic iap_en;
    prot_mode_t prot_mode;
  } nv_cfg_t;

  localparam nv_cfg_t CFG_RESET = '{clk_src: CLK_IRC, startup_delay_sel: 2'h3,
    startup_timeout_us: SUT_RC_3, reset_pin_en: 1'b1, brownout_detector_en: 1'b1,
    on_chip_debug_en: 1'b0, isp_anytime: 1'b1, user_sig_prog_en: 1'b0,
    ports_input_only: 1'b1, ocd_fast_if: 1'b1, iap_en: 1'b0, prot_mode: MODE_OPEN};
endpackage : nvm_pkg

// file: tb/flash_lock_fuse_poll_logic_tb.sv
// Self-checking bench for data polling, lock modes and fuse row
`timescale 1ns/1ps
module flash_lock_fuse_poll_logic_tb;
  import nvm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  nv_cfg_t cfg;
  int err_count = 0, check_count = 0;
  always #2 clk = ~clk;
  nvm_access_top dut_u (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg)
  );
  prog_master prog_u (
    .clk(clk),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    prog_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic op(input logic [9:0] a, input logic [3:0] c, input logic [7:0] d);
    wr(OFF_ADDR, {22'h0, a});
    wr(OFF_CMD, {16'h0, d, 4'h0, c});
  endtask : op
  task automatic pk(input logic [9:0] a, input logic [7:0] e);
    wr(OFF_ADDR, {22'h0, a});
    prog_u.xfer(1'b0, OFF_RDATA, 32'h0, q);
    chk(q, {24'h0, e});
  endtask : pk
  task automatic idle();
    do prog_u.xfer(1'b0, OFF_STATUS, 32'h0, q);
    while (q[ST_BUSY] !== 1'b0);
  endtask : idle
  task automatic t_erase();
    chk(32'(cfg), 32'(CFG_RESET));
    prog_u.xfer(1'b0, 5'h18, 32'h0, q);
    chk(q, 32'h0);
    op(10'h000, CMD_CHIP_ERASE, 8'h00);
    pk(10'h000, 8'h7f);
    idle();
    $display("erase test done");
  endtask : t_erase
  task automatic t_poll();
    wr(OFF_ADDR, 32'h11f);
    wr(OFF_WDATA, 32'h5a);
    wr(OFF_WDATA, 32'h3c);
    op(10'h100, CMD_WRITE_PAGE, 8'h00);
    pk(10'h100, 8'hbc);
    pk(10'h11f, 8'hff);
    idle();
    pk(10'h100, 8'h3c);
    $display("polling test done");
  endtask : t_poll
  task automatic t_fuse();
    op(10'h300, CMD_WRITE_FUSE, 8'h00);
    op(10'h301, CMD_WRITE_FUSE, 8'h00);
    pk(10'h300, 8'h00);
    chk(32'(cfg.clk_src), 32'(CLK_HS_CRYSTAL_OSC));
    chk(32'(cfg.startup_timeout_us), 32'(SUT_CRYSTAL_OSC_3));
    op(10'h304, CMD_WRITE_FUSE_AE, 8'h00);
    pk(10'h301, 8'hff);
    op(10'h304, CMD_SESSION_END, 8'h00);
    pk(10'h304, 8'h00);
    chk(32'(cfg.reset_pin_en), 32'h0);
    chk(32'(cfg.isp_anytime), 32'h1);
    chk(32'(cfg.ocd_fast_if), 32'h1);
    $display("fuse test done");
  endtask : t_fuse
  task automatic t_lock();
    op(10'h310, CMD_WRITE_LOCK, 8'h00);
    prog_u.xfer(1'b0, OFF_STATUS, 32'h0, q);
    chk(q & 32'h6, 32'h2);
    op(10'h305, CMD_WRITE_FUSE, 8'h00);
    pk(10'h305, 8'hff);
    op(10'h311, CMD_WRITE_LOCK, 8'h00);
    pk(10'h100, 8'h00);
    prog_u.xfer(1'b0, OFF_STATUS, 32'h0, q);
    chk(q & 32'h6, 32'h4);
    op(10'h100, CMD_APP_WRITE, 8'h00);
    prog_u.xfer(1'b0, OFF_STATUS, 32'h0, q);
    chk(q & 32'h9, 32'h1);
    idle();
    op(10'h000, CMD_CHIP_ERASE, 8'h00);
    idle();
    pk(10'h310, 8'hff);
    $display("lock test done");
  endtask : t_lock
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_erase();
    t_poll();
    t_fuse();
    t_lock();
    report_and_stop();
  end
endmodule : flash_lock_fuse_poll_logic_tb

// file: tb/prog_master.sv
// Register bus master standing in for the external programmer
`timescale 1ns/1ps
module prog_master (
  input wire logic clk,
  output logic [4:0] avs_address = 5'h00,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [3:0] avs_byteenable = 4'hf,
  output logic [31:0] avs_writedata = 32'h0,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    // Hold the request until waitrequest is sampled low at a rising edge
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : prog_master
